// File: logic/serial_nand_command_bus.sv
// Serial command front end of a NAND flash: framing, commands, features, cache
module serial_nand_command_bus #(
  parameter logic [7:0] MAKER_ID  = 8'hA5, // Arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h3C  // Arbitrary value
) (
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  input  wire logic               ce_in,
  input  wire logic               sclk_in,
  input  wire logic               cs_n_in,
  input  wire logic [3:0]         io_line_in,
  input  wire logic               array_busy_in,
  input  wire logic [11:0]        cache_addr_in,
  input  wire logic [7:0]         cache_wdata_in,
  input  wire logic               cache_we_in,
  output logic [3:0]              io_line_out,
  output logic [3:0]              io_line_oe_out,
  output logic [7:0]              cache_rdata_out,
  output nand_cmd_pkg::array_req_t array_req_out,
  output logic                    array_req_valid_out,
  output logic                    write_latch_bit_out,
  output logic                    paused_out,
  output logic [7:0]              lock_reg_out,
  output logic [7:0]              otp_reg_out
);
  import nand_cmd_pkg::*;

  pins_t       meta_reg, pins_reg;
  logic        sclk_d_reg;
  phase_t      phase_reg, phase_next;
  src_t        src_reg, src_next;
  logic [7:0]  op_reg, op_next, sh_reg, sh_next, tx_reg, tx_next;
  logic [3:0]  cnt_reg, cnt_next, txc_reg, txc_next;
  logic [2:0]  lanes_reg, lanes_next;
  logic [1:0]  left_reg, left_next;
  logic [23:0] addr_reg, addr_next;
  logic [11:0] col_reg, col_next;
  logic        pause_reg, pause_next, wel_reg, wel_next;
  logic [7:0]  lock_reg, lock_next, otp_reg, otp_next, drv_reg, drv_next;
  logic [3:0]  io_reg, io_next, oe_reg, oe_next;
  array_req_t  req_reg, req_next;
  logic        reqv_reg, reqv_next;
  logic        spi_we, cache_clr;
  logic [7:0]  lock_wr;
  logic [7:0]  mem [CACHE_BYTES];
  logic [CACHE_BYTES-1:0] valid_reg;

  // Pins cross in through two flops; only the second stage is looked at
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_reg   <= PINS_IDLE;
      pins_reg   <= PINS_IDLE;
      sclk_d_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      meta_reg   <= '{sclk: sclk_in, cs_n: cs_n_in, io: io_line_in};
      pins_reg   <= meta_reg;
      sclk_d_reg <= pins_reg.sclk;
    end
  end

  // Edge finding; either idle level works since only edges matter
  wire       selected  = ~pins_reg.cs_n;
  wire       rise_raw  = pins_reg.sclk & ~sclk_d_reg;
  wire       fall_raw  = ~pins_reg.sclk & sclk_d_reg;
  wire       rise      = rise_raw & selected & ~pause_reg;
  wire       fall      = fall_raw & selected & ~pause_reg;
  wire       quad_data = (lanes_reg == LANE4);
  // Line 3 carries data in quad phases, so it cannot pause there
  wire       hold_low  = selected & ~pins_reg.io[3] & ~quad_data;
  wire [3:0] cnt_sum   = 4'(cnt_reg + {1'b0, lanes_reg});
  wire [3:0] txc_sum   = 4'(txc_reg + {1'b0, lanes_reg});
  wire       byte_done = rise & (cnt_sum == 4'h8);
  wire       tx_empty  = (txc_sum == 4'h8);
  wire       protect_locked = lock_reg[GUARD_BIT] & ~pins_reg.io[2];

  // Receive and transmit shifting per lane count
  wire [7:0] rx_byte = quad_data ? {sh_reg[3:0], pins_reg.io} :
                       (lanes_reg == LANE2) ? {sh_reg[5:0], pins_reg.io[1:0]} :
                       {sh_reg[6:0], pins_reg.io[0]};
  wire [7:0] tx_shift = quad_data ? {tx_reg[3:0], 4'h0} :
                        (lanes_reg == LANE2) ? {tx_reg[5:0], 2'h0} : {tx_reg[6:0], 1'h0};
  wire [3:0] tx_lines = quad_data ? tx_reg[7:4] :
                        (lanes_reg == LANE2) ? {2'h0, tx_reg[7:6]} : {2'h0, tx_reg[7], 1'h0};
  wire [3:0] tx_oe    = quad_data ? 4'hF : (lanes_reg == LANE2) ? 4'h3 : 4'h2;

  // Cache byte, erased value when cleared or past the end
  function automatic logic [7:0] cache_byte(input logic [11:0] idx);
    cache_byte = ERASED_BYTE;
    if (idx < CACHE_BYTES && valid_reg[idx])
      cache_byte = mem[idx];
  endfunction

  // Feature read value by feature address
  function automatic logic [7:0] feat_rd(input logic [7:0] fa);
    logic [7:0] stat;
    stat          = 8'h00;
    stat[WEL_BIT] = wel_reg;
    stat[OIP_BIT] = array_busy_in;
    case (fa)
      FA_LOCK: feat_rd = lock_reg;
      FA_OTP:  feat_rd = otp_reg;
      FA_STAT: feat_rd = stat;
      FA_DRV:  feat_rd = drv_reg;
      default: feat_rd = 8'h00;
    endcase
  endfunction

  // Guarded lock write keeps the protect levels
  always_comb
  begin
    lock_wr = rx_byte;
    if (protect_locked)
      lock_wr[PROT_HI:PROT_LO] = lock_reg[PROT_HI:PROT_LO];
  end

  // Pause follows hold at once with clock low, else at the next fall
  always_comb
  begin
    pause_next = pause_reg;
    if (!selected)
      pause_next = 1'b0;
    else if ((hold_low != pause_reg) && (!pins_reg.sclk || fall_raw))
      pause_next = hold_low;
  end

  // Command sequencer
  always_comb
  begin
    phase_next = phase_reg;
    src_next   = src_reg;
    op_next    = op_reg;
    sh_next    = sh_reg;
    cnt_next   = cnt_reg;
    lanes_next = lanes_reg;
    left_next  = left_reg;
    addr_next  = addr_reg;
    col_next   = col_reg;
    tx_next    = tx_reg;
    txc_next   = txc_reg;
    wel_next   = wel_reg;
    lock_next  = lock_reg;
    otp_next   = otp_reg;
    drv_next   = drv_reg;
    io_next    = io_reg;
    oe_next    = oe_reg;
    req_next   = req_reg;
    reqv_next  = 1'b0;
    spi_we     = 1'b0;
    cache_clr  = 1'b0;
    if (!selected)
    begin
      phase_next = ST_CMD;
      cnt_next   = 4'h0;
      txc_next   = 4'h0;
      lanes_next = LANE1;
      oe_next    = 4'h0;
    end
    else
    begin
      if (pause_reg)
        oe_next = 4'h0;
      if (rise && phase_reg != ST_DOUT)
      begin
        sh_next  = rx_byte;
        cnt_next = byte_done ? 4'h0 : cnt_sum;
      end
      if (byte_done)
      begin
        case (phase_reg)
          ST_CMD:
          begin
            op_next    = rx_byte;
            phase_next = ST_SKIP;
            case (rx_byte)
              OP_WREN: wel_next = 1'b1;
              OP_WRDI: wel_next = 1'b0;
              OP_RST:
              begin
                wel_next    = 1'b0;
                reqv_next   = 1'b1;
                req_next.op = AOP_RESET;
              end
              OP_GETF, OP_SETF:
              begin
                phase_next = ST_ADDR;
                left_next  = 2'h0;
              end
              OP_PGRD, OP_EXEC, OP_ERASE:
              begin
                phase_next = ST_ADDR;
                left_next  = 2'h2;
              end
              OP_RD1, OP_RDF, OP_RD2, OP_RD4, OP_LDR, OP_LDR4:
              begin
                phase_next = ST_ADDR;
                left_next  = 2'h1;
              end
              OP_LD, OP_LD4:
              begin
                phase_next = ST_ADDR;
                left_next  = 2'h1;
                cache_clr  = 1'b1;
              end
              OP_ID: phase_next = ST_DUMMY;
              default: ;
            endcase
          end
          ST_ADDR:
          begin
            addr_next = {addr_reg[15:0], rx_byte};
            col_next  = addr_next[11:0];
            if (left_reg != 2'h0)
              left_next = left_reg - 2'h1;
            else
            begin
              phase_next = ST_SKIP;
              case (op_reg)
                OP_GETF:
                begin
                  phase_next = ST_DOUT;
                  src_next   = SRC_FEAT;
                  tx_next    = feat_rd(rx_byte);
                  txc_next   = 4'h0;
                end
                OP_SETF: phase_next = ST_DIN;
                OP_PGRD:
                begin
                  reqv_next = 1'b1;
                  req_next  = '{op: AOP_READ, row: addr_next[15:0]};
                end
                OP_EXEC:
                begin
                  reqv_next = wel_reg;
                  req_next  = '{op: AOP_PROG, row: addr_next[15:0]};
                end
                OP_ERASE:
                begin
                  reqv_next = wel_reg;
                  req_next  = '{op: AOP_ERASE, row: addr_next[15:0]};
                end
                OP_LD, OP_LDR: phase_next = ST_DIN;
                OP_LD4, OP_LDR4:
                begin
                  phase_next = ST_DIN;
                  lanes_next = LANE4;
                end
                default: phase_next = ST_DUMMY;
              endcase
            end
          end
          ST_DUMMY:
          begin
            phase_next = ST_DOUT;
            txc_next   = 4'h0;
            src_next   = SRC_CACHE;
            tx_next    = cache_byte(col_reg);
            col_next   = col_reg + 12'h001;
            case (op_reg)
              OP_ID:
              begin
                src_next = SRC_ID;
                tx_next  = MAKER_ID;
                col_next = col_reg;
              end
              OP_RD2:  lanes_next = LANE2;
              OP_RD4:  lanes_next = LANE4;
              default: lanes_next = LANE1;
            endcase
          end
          ST_DIN:
          begin
            if (op_reg == OP_SETF)
            begin
              phase_next = ST_SKIP;
              case (addr_reg[7:0])
                FA_LOCK: lock_next = lock_wr;
                FA_OTP:  otp_next = rx_byte;
                FA_DRV:  drv_next = rx_byte;
                default: ;
              endcase
            end
            else
            begin
              spi_we   = 1'b1;
              col_next = col_reg + 12'h001;
            end
          end
          default: ;
        endcase
      end
      // Launch after falling edges, next byte fetched as the last bits go
      if (fall && phase_reg == ST_DOUT)
      begin
        io_next  = tx_lines;
        oe_next  = tx_oe;
        tx_next  = tx_shift;
        txc_next = tx_empty ? 4'h0 : txc_sum;
        if (tx_empty)
        begin
          case (src_reg)
            SRC_FEAT: tx_next = feat_rd(addr_reg[7:0]);
            SRC_ID:   tx_next = DEVICE_ID;
            default:
            begin
              tx_next  = cache_byte(col_reg);
              col_next = col_reg + 12'h001;
            end
          endcase
        end
      end
    end
  end

  // Sequencer state; ce_in low freezes it all
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      phase_reg                                    <= ST_CMD;
      src_reg                                      <= SRC_FEAT;
      {op_reg, sh_reg, tx_reg}                     <= 24'h0;
      {cnt_reg, txc_reg, lanes_reg, left_reg}      <= {8'h00, LANE1, 2'h0};
      {addr_reg, col_reg, pause_reg, wel_reg}      <= 38'h0;
      {lock_reg, otp_reg, drv_reg}                 <= {LOCK_RST, OTP_RST, DRV_RST};
      {io_reg, oe_reg, req_reg, reqv_reg}          <= {8'h00, AOP_NONE, 17'h0};
    end
    else if (ce_in)
    begin
      // Enum states kept out of the packed group so no bits are cast silently
      phase_reg                                    <= phase_next;
      src_reg                                      <= src_next;
      {op_reg, sh_reg, tx_reg}                     <= {op_next, sh_next, tx_next};
      {cnt_reg, txc_reg, lanes_reg, left_reg}      <= {cnt_next, txc_next, lanes_next, left_next};
      {addr_reg, col_reg, pause_reg, wel_reg}      <= {addr_next, col_next, pause_next, wel_next};
      {lock_reg, otp_reg, drv_reg}                 <= {lock_next, otp_next, drv_next};
      {io_reg, oe_reg, req_reg, reqv_reg}          <= {io_next, oe_next, req_next, reqv_next};
    end
  end

  // Cache storage; serial loads win over the array engine port
  always_ff @(posedge clk_in)
  begin
    if (ce_in && spi_we && col_reg < CACHE_BYTES)
      mem[col_reg] <= rx_byte;
    else if (ce_in && cache_we_in && cache_addr_in < CACHE_BYTES)
      mem[cache_addr_in] <= cache_wdata_in;
  end

  // Written-byte map makes a cache clear a single cycle
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      valid_reg       <= '0;
      cache_rdata_out <= 8'h00;
    end
    else if (ce_in)
    begin
      cache_rdata_out <= cache_byte(cache_addr_in);
      if (cache_clr)
        valid_reg <= '0;
      else if (spi_we && col_reg < CACHE_BYTES)
        valid_reg[col_reg] <= 1'b1;
      else if (cache_we_in && cache_addr_in < CACHE_BYTES)
        valid_reg[cache_addr_in] <= 1'b1;
    end
  end

  // Outputs straight from flops
  assign io_line_out         = io_reg;
  assign io_line_oe_out      = oe_reg;
  assign array_req_out       = req_reg;
  assign array_req_valid_out = reqv_reg;
  assign write_latch_bit_out = wel_reg;
  assign paused_out          = pause_reg;
  assign lock_reg_out        = lock_reg;
  assign otp_reg_out         = otp_reg;

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence seq_op(logic [7:0] b);
    ce_in && phase_reg == ST_CMD && byte_done && rx_byte == b;
  endsequence
  sequence seq_paused;
    ce_in && pause_reg && selected;
  endsequence

  AST_WREN: assert property (seq_op(OP_WREN) |=> wel_reg)
    else $error("write enable did not set latch");
  AST_WRDI: assert property (seq_op(OP_WRDI) |=> !wel_reg)
    else $error("write disable did not clear latch");
  AST_ARRAY_NEEDS_WEL: assert property (reqv_reg && req_reg.op inside {AOP_PROG, AOP_ERASE} |-> wel_reg)
    else $error("program or erase without write latch");
  AST_DESELECT_HIZ: assert property (ce_in && !selected |=> io_line_oe_out == 4'h0)
    else $error("output driven while deselected");
  AST_PAUSE_HIZ: assert property (seq_paused |=> io_line_oe_out == 4'h0 && $stable(sh_reg))
    else $error("activity while paused");
  AST_PAUSE_ENTER: assert property (ce_in && !pause_reg && hold_low && !pins_reg.sclk |=> pause_reg)
    else $error("pause not entered with clock low");
  AST_PAUSE_EXIT: assert property (seq_paused ##0 !hold_low && !pins_reg.sclk |=> !pause_reg)
    else $error("pause not left with clock low");
  AST_LOCK_GUARD: assert property (ce_in && protect_locked |=> $stable(lock_reg[PROT_HI:PROT_LO]))
    else $error("protect levels changed while guarded");
  AST_SINGLE_LINE: assert property (phase_reg == ST_DOUT && lanes_reg == LANE1 |-> !oe_reg[0])
    else $error("line 0 driven in single read");
  AST_LAUNCH_ON_FALL: assert property ($changed(io_line_out) |-> $past(fall_raw))
    else $error("output changed without falling clock");
  AST_DUAL_LANES: assert property (ce_in && phase_reg == ST_DUMMY && byte_done && op_reg == OP_RD2
                                   |=> phase_reg == ST_DOUT && lanes_reg == LANE2)
    else $error("dual read not on two lines");
endmodule // serial_nand_command_bus

// File: inc/nand_cmd_pkg.sv
// Opcodes, feature layout and types for the serial NAND command front end
package nand_cmd_pkg;
  localparam int         CACHE_BYTES = 2112;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] OP_WREN     = 8'h06;
  localparam logic [7:0] OP_WRDI     = 8'h04;
  localparam logic [7:0] OP_GETF     = 8'h0F;
  localparam logic [7:0] OP_SETF     = 8'h1F;
  localparam logic [7:0] OP_PGRD     = 8'h13;
  localparam logic [7:0] OP_RD1      = 8'h03;
  localparam logic [7:0] OP_RDF      = 8'h0B;
  localparam logic [7:0] OP_RD2      = 8'h3B;
  localparam logic [7:0] OP_RD4      = 8'h6B;
  localparam logic [7:0] OP_LD       = 8'h02;
  localparam logic [7:0] OP_LD4      = 8'h32;
  localparam logic [7:0] OP_LDR      = 8'h84;
  localparam logic [7:0] OP_LDR4     = 8'h34;
  localparam logic [7:0] OP_EXEC     = 8'h10;
  localparam logic [7:0] OP_ERASE    = 8'hD8;
  localparam logic [7:0] OP_ID       = 8'h9F;
  localparam logic [7:0] OP_RST      = 8'hFF;
  localparam logic [7:0] FA_LOCK     = 8'hA0;
  localparam logic [7:0] FA_OTP      = 8'hB0;
  localparam logic [7:0] FA_STAT     = 8'hC0;
  localparam logic [7:0] FA_DRV      = 8'hD0;
  localparam int         GUARD_BIT   = 7;
  localparam int         PROT_HI     = 5;
  localparam int         PROT_LO     = 3;
  localparam int         WEL_BIT     = 1;
  localparam int         OIP_BIT     = 0;
  localparam logic [7:0] LOCK_RST    = 8'h00;
  localparam logic [7:0] OTP_RST     = 8'h10;
  localparam logic [7:0] DRV_RST     = 8'h00;
  localparam logic [2:0] LANE1       = 3'h1;
  localparam logic [2:0] LANE2       = 3'h2;
  localparam logic [2:0] LANE4       = 3'h4;

  typedef enum logic [2:0] {
    ST_CMD = 3'b000, ST_ADDR = 3'b001, ST_DUMMY = 3'b010,
    ST_DIN = 3'b011, ST_DOUT = 3'b100, ST_SKIP = 3'b101
  } phase_t;
  typedef enum logic [1:0] {SRC_FEAT = 2'b00, SRC_ID = 2'b01, SRC_CACHE = 2'b10} src_t;
  typedef enum logic [2:0] {
    AOP_NONE = 3'b000, AOP_READ = 3'b001, AOP_PROG = 3'b010,
    AOP_ERASE = 3'b011, AOP_RESET = 3'b100
  } aop_t;
  typedef struct packed {
    logic       sclk;
    logic       cs_n;
    logic [3:0] io;
  } pins_t;
  typedef struct packed {
    aop_t        op;
    logic [15:0] row;
  } array_req_t;

  localparam pins_t PINS_IDLE = 6'h1F;
endpackage

// File: tb/nand_host_model.sv
// Host serial controller model driving the serial NAND front end pins
module nand_host_model (
  input  wire logic       clk_in,
  input  wire logic [3:0] io_in,
  output logic            sclk_out,
  output logic            cs_n_out,
  output logic [3:0]      io_out,
  output logic [3:0]      io_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] drv;
  logic [3:0] junk;
  logic [3:0] seen;
  logic       cpol;
  initial
  begin
    sclk_out  = 1'b0;
    cs_n_out  = 1'b1;
    drv       = 4'hC;
    io_oe_out = 4'hD;
    junk      = 4'h5;
    cpol      = 1'b0;
  end
  // Released lines toggle each cycle, so a stale level never passes for data
  always @(posedge clk_in) junk <= ~junk;
  always_ff @(posedge clk_in) seen <= io_in;
  assign io_out = (drv & io_oe_out) | (junk & ~io_oe_out);
  task automatic half();
    repeat (8) @(posedge clk_in);
  endtask
  // Clock idles at the mode's level before select and after the frame
  task automatic go(input logic pol);
    cpol = pol;
    sclk_out <= pol;
    half();
    cs_n_out <= 1'b0;
    half();
  endtask
  // Lines 0, 2 and 3 are driven again only once the frame has closed
  task automatic stop();
    sclk_out <= cpol;
    half();
    cs_n_out <= 1'b1;
    half();
    io_oe_out <= 4'hD;
    drv <= 4'hC;
    half();
  endtask
  task automatic fall();
    sclk_out <= 1'b0;
    half();
  endtask
  task automatic hold(input logic v);
    drv[3] <= v;
  endtask
  task automatic wp(input logic v);
    drv[2] <= v;
  endtask
  // One byte: data set at the fall, taken by the device at the rise
  task automatic xfer(input logic [7:0] d, input int n, input bit rd, output logic [7:0] q);
    int k;
    q = 8'h00;
    for (k = 8 - n; k >= 0; k -= n)
    begin
      sclk_out <= 1'b0;
      io_oe_out <= rd ? (n == 1 ? 4'hD : n == 2 ? 4'hC : 4'h0) : (n == 4 ? 4'hF : 4'hD);
      if (n == 4) drv <= d[k+:4];
      else drv[0] <= d[k];
      half();
      if (n == 4) q[k+:4] = seen;
      else if (n == 2) q[k+:2] = seen[1:0];
      else q[k] = seen[1];
      sclk_out <= 1'b1;
      half();
    end
  endtask
endmodule // nand_host_model

// File: tb/serial_nand_command_bus_tb_top.sv
// Self-checking bench for the serial NAND command front end
module serial_nand_command_bus_tb_top;
  import nand_cmd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
  localparam logic [7:0] DEV   = 8'hC3; // Arbitrary value
  logic       clk_in, rst_in, ce, busy, we, sclk, cs_n, req_v, write_latch_bit, paused;
  logic [11:0] ca;
  logic [7:0] cd, rd, lock, otp, q;
  logic [3:0] h_io, h_oe, d_io, d_oe, io;
  array_req_t req, last;
  int         miscompares, checks_done, nreq, i;
  // Wire level: device wins where it drives, otherwise the host's line
  assign io = (d_io & d_oe) | (h_io & ~d_oe);
  nand_host_model host_u (.clk_in(clk_in), .io_in(io), .sclk_out(sclk), .cs_n_out(cs_n), .io_out(h_io),
    .io_oe_out(h_oe));
  serial_nand_command_bus #(.MAKER_ID(MAKER), .DEVICE_ID(DEV)) dut_u (.clk_in(clk_in), .rst_in(rst_in),
    .ce_in(ce), .sclk_in(sclk), .cs_n_in(cs_n), .io_line_in(io), .array_busy_in(busy), .cache_addr_in(ca),
    .cache_wdata_in(cd), .cache_we_in(we), .io_line_out(d_io), .io_line_oe_out(d_oe), .cache_rdata_out(rd),
    .array_req_out(req), .array_req_valid_out(req_v), .write_latch_bit_out(write_latch_bit), .paused_out(paused),
    .lock_reg_out(lock), .otp_reg_out(otp));
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Array requests are counted so a missing or extra pulse shows
  always @(posedge clk_in)
  begin
    if (req_v === 1'b1)
    begin
      nreq++;
      last = req;
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, s, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic w(input logic [7:0] d);
    host_u.xfer(d, 1, 1'b0, q);
  endtask
  // Whole frame: opcode then n bytes of a, highest first
  task automatic cmd(input logic [7:0] op, input logic pol, input int n, input logic [31:0] a);
    host_u.go(pol);
    w(op);
    for (int k = n - 1; k >= 0; k--) w(a[8*k+:8]);
    host_u.stop();
  endtask
  task automatic cw(input logic [11:0] a, input logic [7:0] d);
    ca <= a;
    cd <= d;
    we <= 1'b1;
    wt(1);
    we <= 1'b0;
  endtask
  task automatic cr(input logic [11:0] a, output logic [7:0] v);
    ca <= a;
    wt(2);
    v = rd;
  endtask
  task automatic t_latch();
    cmd(OP_WREN, 1'b1, 0, 0);
    chk(write_latch_bit, 1);
    cmd(OP_ERASE, 1'b0, 3, 24'h001234);
    chk(last, {AOP_ERASE, 16'h1234});
    cmd(OP_WRDI, 1'b0, 0, 0);
    chk(write_latch_bit, 0);
    cmd(OP_EXEC, 1'b0, 3, 24'h000007);
    chk(nreq, 1);
    cmd(OP_WREN, 1'b0, 0, 0);
    cmd(OP_EXEC, 1'b0, 3, 24'h000007);
    chk(last, {AOP_PROG, 16'h0007});
    cmd(OP_PGRD, 1'b0, 3, 24'hFF5678);
    chk(last, {AOP_READ, 16'h5678});
    cmd(OP_RST, 1'b0, 0, 0);
    chk(nreq, 4);
  endtask
  task automatic t_feat();
    cmd(OP_SETF, 1'b0, 2, {FA_LOCK, 8'hB8});
    chk(lock, 8'hB8);
    host_u.wp(1'b0);
    cmd(OP_SETF, 1'b0, 2, {FA_LOCK, 8'h80});
    chk(lock, 8'hB8);
    // Protect pin back high: the guard alone must not hold the levels
    host_u.wp(1'b1);
    cmd(OP_SETF, 1'b0, 2, {FA_LOCK, 8'h80});
    chk(lock, 8'h80);
    cmd(OP_WREN, 1'b0, 0, 0);
    cmd(OP_SETF, 1'b0, 2, {FA_STAT, 8'h00});
    busy <= 1'b1;
    host_u.go(1'b0);
    w(OP_GETF);
    w(FA_STAT);
    host_u.xfer(8'h00, 1, 1'b1, q);
    chk(q, 8'h03);
    host_u.stop();
    busy <= 1'b0;
  endtask
  // Pause in mid-frame: bits clocked while paused must not count
  task automatic t_hold();
    host_u.go(1'b0);
    w(OP_SETF);
    host_u.hold(1'b0);
    wt(6);
    chk(paused, 0);
    host_u.fall();
    chk(paused, 1);
    chk(d_oe, 0);
    w(8'hFF);
    host_u.fall();
    host_u.hold(1'b1);
    wt(6);
    chk(paused, 0);
    w(FA_LOCK);
    w(8'h28);
    host_u.stop();
    chk(lock, 8'h28);
  endtask
  task automatic t_id();
    host_u.go(1'b0);
    w(OP_ID);
    w(8'h00);
    host_u.xfer(8'h00, 1, 1'b1, q);
    chk(q, MAKER);
    host_u.xfer(8'h00, 1, 1'b1, q);
    chk(q, DEV);
    host_u.stop();
  endtask
  // Every cache read mode from the last column, then one past it
  task automatic t_read();
    logic [7:0] ops [4] = '{OP_RD1, OP_RDF, OP_RD2, OP_RD4};
    int         ln  [4] = '{1, 1, 2, 4};
    logic [3:0] oes [4] = '{4'h2, 4'h2, 4'h3, 4'hF};
    chk(otp, OTP_RST);
    cmd(OP_SETF, 1'b0, 2, {FA_OTP, 8'h11});
    chk(otp, 8'h11);
    cw(12'h83F, 8'h96);
    for (i = 0; i < 4; i++)
    begin
      cmd(ops[i], 1'b0, -1, 0);
      host_u.go(1'b0);
      w(ops[i]);
      w(8'h08);
      w(8'h3F);
      w(8'h00);
      host_u.xfer(8'h00, ln[i], 1'b1, q);
      chk(q, 8'h96);
      host_u.xfer(8'h00, ln[i], 1'b1, q);
      chk(q, 8'hFF);
      chk(d_oe, oes[i]);
      host_u.stop();
      chk(d_oe, 0);
    end
  endtask
  task automatic ld4(input logic [7:0] op, input logic [7:0] col, input logic [7:0] d);
    host_u.go(1'b0);
    w(op);
    w(8'h00);
    w(col);
    host_u.xfer(d, 4, 1'b0, q);
    host_u.stop();
  endtask
  task automatic t_load();
    cw(12'h020, 8'h77);
    cmd(OP_LDR, 1'b0, 4, 32'h0010_1122);
    cr(12'h011, q);
    chk(q, 8'h22);
    cr(12'h020, q);
    chk(q, 8'h77);
    ld4(OP_LD4, 8'h20, 8'h5A);
    cr(12'h020, q);
    chk(q, 8'h5A);
    cr(12'h010, q);
    chk(q, 8'hFF);
    cmd(OP_LD, 1'b0, 3, 24'h00123C);
    cr(12'h012, q);
    chk(q, 8'h3C);
    cr(12'h020, q);
    chk(q, 8'hFF);
    ld4(OP_LDR4, 8'h13, 8'h4D);
    cr(12'h013, q);
    chk(q, 8'h4D);
    cr(12'h012, q);
    chk(q, 8'h3C);
  endtask
  // Clock enable low: a whole frame and an engine write must leave no trace
  task automatic t_freeze();
    ce <= 1'b0;
    cmd(OP_WRDI, 1'b0, 0, 0);
    cw(12'h030, 8'hAA);
    ce <= 1'b1;
    wt(4);
    chk(write_latch_bit, 1);
    cr(12'h030, q);
    chk(q, 8'hFF);
    cmd(OP_WRDI, 1'b0, 0, 0);
    chk(write_latch_bit, 0);
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Run is about 0.13 ms; over three times that means a hang
  initial
  begin
    #500_000;
    miscompares++;
    final_report();
  end
  initial
  begin
    rst_in = 1'b1;
    ce = 1'b1;
    busy = 1'b0;
    we = 1'b0;
    ca = 12'h000;
    cd = 8'h00;
    wt(20);
    rst_in <= 1'b0;
    wt(5);
    t_latch();
    t_feat();
    t_hold();
    t_id();
    t_read();
    t_load();
    t_freeze();
    final_report();
  end
endmodule // serial_nand_command_bus_tb_top
